// file: verilog/bcd_pkg.sv
`default_nettype none
package bcd_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int LOCK_TIME_MS = 3500;
   localparam int LOCK_CYCLES_DEF = LOCK_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int ZERO_DUTY_PERIODS = 8;
   localparam logic [7:0] CUR_LIMIT_LEVEL = 8'h80;

   typedef struct packed {
      logic [7:0] pos;
      logic [7:0] neg;
   } bcd_hall_t;

   typedef struct packed {
      logic run_n;
      logic short_brake_n;
      logic duty_pulse_in_n;
      logic reverse;
   } bcd_ctl_t;

   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } bcd_drive_t;

   typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_BRAKE} bcd_mode_t;

   typedef struct packed {
      logic [2:0] hall_s1;
      logic [2:0] hall_s2;
      logic [2:0] hall_prev;
      logic cm_s1;
      logic cm_s2;
      bcd_ctl_t ctl_s1;
      bcd_ctl_t ctl_s2;
      logic [7:0] ramp;
      logic cur_lim;
      logic period_on;
      logic [3:0] zero_cnt;
      logic [31:0] lock_cnt;
      logic locked;
      logic rot;
      bcd_drive_t drive;
   } bcd_state_t;

   localparam bcd_ctl_t CTL_RST = 4'hE;
   localparam bcd_state_t STATE_RST = '{ctl_s1: CTL_RST, ctl_s2: CTL_RST, default: '0};
endpackage
`default_nettype wire

// file: verilog/bcd_drive_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_drive_ctrl
   import bcd_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEF
)
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire bcd_hall_t [2:0] HALL_I,
   input wire bcd_ctl_t CTL_I,
   input wire logic [7:0] DUTY_THRESHOLD_LEVEL_I,
   input wire logic [7:0] OSC_PERIOD_I,
   input wire logic [7:0] CURRENT_SENSE_NODE_I,
   output bcd_drive_t PHASE_DRIVE_O,
   output logic ROTATION_COMPOSITE_OUT_O,
   output logic ROTATION_COMPOSITE_OUT_OE_O,
   output logic LOCKED_O
);

   // ************************************************************
   // Hall comparators
   // ************************************************************
   logic [2:0] hall_raw;
   logic [2:0] hall_cm;

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : gen_hall
         assign hall_raw[g] = HALL_I[g].pos > HALL_I[g].neg;
         // Equal levels read low and flag common mode
         assign hall_cm[g] = HALL_I[g].pos == HALL_I[g].neg;
      end
   endgenerate

   // ************************************************************
   // State
   // ************************************************************
   bcd_state_t s;
   bcd_state_t next_s;
   bcd_mode_t mode;
   bcd_drive_t comm;
   logic [2:0] hall_dir;
   logic wrap;
   logic duty_on;
   logic any_on;

   always_comb
   begin
      next_s = s;
      next_s.hall_s1 = hall_raw;
      next_s.hall_s2 = s.hall_s1;
      next_s.cm_s1 = &hall_cm;
      next_s.cm_s2 = s.cm_s1;
      next_s.ctl_s1 = CTL_I;
      next_s.ctl_s2 = s.ctl_s1;
      // Last synced Hall, the reference for lock and edge detection
      next_s.hall_prev = s.hall_s2;
      // composite toggles on every Hall edge
      next_s.rot = ^s.hall_s2;

      // run input low starts, brake input low brakes
      if (s.ctl_s2.run_n)
      begin
         mode = MODE_STOP;
      end
      else if (!s.ctl_s2.short_brake_n)
      begin
         mode = MODE_BRAKE;
      end
      else
      begin
         mode = MODE_RUN;
      end

      // Stands in for the capacitor oscillator; period is OSC_PERIOD_I plus one
      // oscillator ramp
      wrap = s.ramp >= OSC_PERIOD_I;
      next_s.ramp = wrap ? 8'h00 : s.ramp + 8'h01;

      // pulse input gates, lower threshold widens duty
      duty_on = !s.ctl_s2.duty_pulse_in_n && (s.ramp >= DUTY_THRESHOLD_LEVEL_I);

      // peak limit holds until the next period; a hit wins over the clear
      if (mode == MODE_RUN && CURRENT_SENSE_NODE_I >= CUR_LIMIT_LEVEL)
      begin
         next_s.cur_lim = 1'b1;
      end
      else if (wrap || mode != MODE_RUN)
      begin
         next_s.cur_lim = 1'b0;
      end

      // Zero-duty period counting
      // Saturates one above the limit so the lock clear keeps holding
      any_on = s.period_on | duty_on;
      next_s.period_on = wrap ? 1'b0 : any_on;
      if (wrap)
      begin
         if (any_on)
         begin
            next_s.zero_cnt = 4'h0;
         end
         else if (s.zero_cnt <= 4'(ZERO_DUTY_PERIODS))
         begin
            next_s.zero_cnt = s.zero_cnt + 4'h1;
         end
      end

      // lock timer runs only while driving
      case (mode)
         MODE_RUN:
         begin
            // A Hall edge restarts the count but does not release a lock
            if (s.hall_s2 != s.hall_prev)
            begin
               next_s.lock_cnt = '0;
            end
            else if (!s.locked)
            begin
               if (s.lock_cnt >= LOCK_CYCLES - 1)
               begin
                  next_s.locked = 1'b1;
               end
               else
               begin
                  next_s.lock_cnt = s.lock_cnt + 32'h1;
               end
            end
         end
         MODE_BRAKE:
         begin
            next_s.lock_cnt = '0;
         end
         default:
         begin
            next_s.lock_cnt = '0;
            next_s.locked = 1'b0;
         end
      endcase
      // long zero duty clears the lock
      if (s.zero_cnt > 4'(ZERO_DUTY_PERIODS))
      begin
         next_s.locked = 1'b0;
         next_s.lock_cnt = '0;
      end

      hall_dir = s.hall_s2 ^ {3{s.ctl_s2.reverse}};
      case ({hall_dir[0], hall_dir[1], hall_dir[2]})
         3'b101: comm = '{hi: 3'b010, lo: 3'b001};
         3'b100: comm = '{hi: 3'b100, lo: 3'b001};
         3'b110: comm = '{hi: 3'b100, lo: 3'b010};
         3'b010: comm = '{hi: 3'b001, lo: 3'b010};
         3'b011: comm = '{hi: 3'b001, lo: 3'b100};
         3'b001: comm = '{hi: 3'b010, lo: 3'b100};
         default: comm = '0;
      endcase

      // With no Hall signal (all pairs in common mode) all off is the only safe choice, brake included
      // common mode overrides every mode
      if (s.cm_s2)
      begin
         next_s.drive = '0;
      end
      else
      begin
         case (mode)
            MODE_BRAKE:
            begin
               // short brake through the high sides
               next_s.drive = '{hi: 3'b111, lo: 3'b000};
            end
            MODE_RUN:
            begin
               next_s.drive.hi = comm.hi;
               next_s.drive.lo = comm.lo & {3{duty_on & ~s.cur_lim & ~s.locked}};
            end
            default:
            begin
               next_s.drive = '0;
            end
         endcase
      end
   end

   // Clock enable freezes everything, synchronizers included
   // Reset ignores the enable so a frozen block can still be cleared
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         s <= STATE_RST;
      end
      else if (CE_I)
      begin
         s <= next_s;
      end
   end

   assign PHASE_DRIVE_O = s.drive;
   assign ROTATION_COMPOSITE_OUT_O = 1'b0;
   // Open collector pulls low while the composite is low
   assign ROTATION_COMPOSITE_OUT_OE_O = ~s.rot;
   assign LOCKED_O = s.locked;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   chk_brake_drive: assert property (
      CE_I && mode == MODE_BRAKE && !s.cm_s2 |=> s.drive == 6'b111000)
      else $error("brake drive wrong");
   chk_pulse_off: assert property (
      CE_I && s.ctl_s2.duty_pulse_in_n |=> s.drive.lo == 3'b000)
      else $error("low side on with pulse high");
   chk_high_steady: assert property (
      CE_I && mode == MODE_RUN && !s.cm_s2 |=> s.drive.hi == $past(comm.hi))
      else $error("high side not held");
   chk_stop_off: assert property (
      CE_I && s.ctl_s2.run_n |=> s.drive == '0)
      else $error("drive on in stop");
   chk_duty_on: assert property (
      CE_I && mode == MODE_RUN && !s.cm_s2 && !s.locked && !s.cur_lim && duty_on
      |=> s.drive.lo == $past(comm.lo))
      else $error("low side missing in duty");
   chk_hall_sync: assert property (
      (CE_I && !RST_I && HALL_I[0].pos > HALL_I[0].neg) [*3] |-> s.hall_s2[0])
      else $error("Hall read or sync wrong");
   chk_hall_low: assert property (
      (CE_I && !RST_I && HALL_I[2].pos < HALL_I[2].neg) [*3] |-> !s.hall_s2[2])
      else $error("Hall low read wrong");
   chk_ce_freeze: assert property (
      !CE_I && !RST_I |=> $stable(s))
      else $error("state moved with enable low");
   chk_common_off: assert property (
      CE_I && s.cm_s2 |=> s.drive == '0)
      else $error("drive on in common mode");
   chk_rotation: assert property (
      (CE_I && !RST_I) [*3] |=> ROTATION_COMPOSITE_OUT_OE_O == ~^$past(hall_raw, 3))
      else $error("composite output mismatch");
   chk_lock_restart: assert property (
      CE_I && mode == MODE_RUN && s.hall_s2 != s.hall_prev |=> s.lock_cnt == 0)
      else $error("lock timer not restarted");
   chk_lock_set: assert property (
      CE_I && mode == MODE_RUN && s.hall_s2 == s.hall_prev && !s.locked
      && s.zero_cnt <= 4'(ZERO_DUTY_PERIODS) && s.lock_cnt == LOCK_CYCLES - 1 |=> s.locked)
      else $error("lock not taken at timeout");
   chk_cur_limit: assert property (
      CE_I && s.cur_lim |=> s.drive.lo == 3'b000)
      else $error("low side on in limit");
   chk_ramp_wrap: assert property (
      CE_I && s.ramp >= OSC_PERIOD_I |=> s.ramp == 8'h00)
      else $error("ramp did not wrap");
   chk_dir_mirror: assert property (
      CE_I && mode == MODE_RUN && !s.cm_s2 && s.ctl_s2.reverse && s.hall_s2 == 3'b010
      |=> s.drive.hi == 3'b010)
      else $error("reverse mapping wrong");
   chk_brake_nolock: assert property (
      CE_I && mode == MODE_BRAKE |=> s.lock_cnt == 0 && !s.cur_lim)
      else $error("protection active in brake");
   chk_lock_lowoff: assert property (
      CE_I && s.locked |=> s.drive.lo == 3'b000)
      else $error("low side on while locked");
   chk_lock_clear: assert property (
      CE_I && (s.ctl_s2.run_n || s.zero_cnt > 4'(ZERO_DUTY_PERIODS)) |=> !s.locked)
      else $error("lock not cleared");
   chk_zero_restart: assert property (
      CE_I && s.ramp >= OSC_PERIOD_I && (s.period_on || duty_on) |=> s.zero_cnt == 4'h0)
      else $error("zero duty count not restarted");
   chk_lock_hold: assert property (
      CE_I && s.locked && mode == MODE_RUN && s.zero_cnt <= 4'(ZERO_DUTY_PERIODS) |=> s.locked)
      else $error("lock released while driving");
   chk_cur_set: assert property (
      CE_I && mode == MODE_RUN && CURRENT_SENSE_NODE_I >= CUR_LIMIT_LEVEL |=> s.cur_lim)
      else $error("current limit not taken");
   chk_run_start: assert property (
      CE_I && mode == MODE_RUN && !s.cm_s2 && !s.ctl_s2.reverse && s.hall_s2 == 3'b101
      |=> s.drive.hi == 3'b010)
      else $error("run did not drive");
   chk_dir_second: assert property (
      CE_I && mode == MODE_RUN && !s.cm_s2 && s.ctl_s2.reverse && s.hall_s2 == 3'b110
      |=> s.drive.hi == 3'b100)
      else $error("second reverse mapping wrong");

   // ************************************************************
   // Coverage
   // ************************************************************
   cov_brake: cover property (CE_I && mode == MODE_BRAKE);
   cov_locked: cover property (s.locked ##1 !s.locked);
   cov_limit: cover property (s.cur_lim ##1 !s.cur_lim);
   cov_reverse: cover property (mode == MODE_RUN && s.ctl_s2.reverse && s.drive.lo != 0);
   cov_zero_clear: cover property (s.locked && s.zero_cnt > 4'(ZERO_DUTY_PERIODS) ##1 !s.locked);

endmodule
`default_nettype wire

// file: bench/bcd_hall_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_hall_model
   import bcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic [2:0] bits_i,
   input wire logic cm_i,
   output var bcd_hall_t [2:0] hall_o
);
   // *****
   // Hall sensor pairs
   // *****
   // Common level wanders every cycle so only the difference carries the state
   logic [7:0] wob = 8'h00;
   always_ff @(posedge clk_i)
   begin
      wob <= wob + 8'h01;
   end
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         hall_o[i].neg = 8'h40 + {4'h0, wob[3:0]};
         hall_o[i].pos = cm_i ? 8'h40 + {4'h0, wob[3:0]} : (bits_i[2 - i] ? 8'h70 : 8'h10);
      end
   end
endmodule
`default_nettype wire

// file: bench/bcd_drive_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_drive_ctrl_tb;
   import bcd_pkg::*;
   localparam int LOCK_N = 200;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cm = 1'b0;
   logic [2:0] hb = 3'h5;
   logic [7:0] thr = 8'h00;
   logic [7:0] per = 8'h09;
   logic [7:0] cur = 8'h00;
   bcd_ctl_t ctl = CTL_RST;
   bcd_hall_t [2:0] hall;
   bcd_drive_t drv;
   logic od;
   logic oe;
   logic lck;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;

   bcd_hall_model bcd_hall_model_inst (.clk_i(clk), .bits_i(hb), .cm_i(cm), .hall_o(hall));
   bcd_drive_ctrl #(.LOCK_CYCLES(LOCK_N)) bcd_drive_ctrl_inst (.CLK_I(clk), .RST_I(rst), .CE_I(ce),
      .HALL_I(hall), .CTL_I(ctl), .DUTY_THRESHOLD_LEVEL_I(thr), .OSC_PERIOD_I(per),
      .CURRENT_SENSE_NODE_I(cur), .PHASE_DRIVE_O(drv), .ROTATION_COMPOSITE_OUT_O(od),
      .ROTATION_COMPOSITE_OUT_OE_O(oe), .LOCKED_O(lck));

   initial
   begin
      forever #10 clk = ~clk;
   end

   // *****
   // Reference model and checks
   // *****
   function automatic logic [5:0] model(input logic [2:0] h, input bcd_ctl_t c, input logic lo_ok);
      logic [5:0] d;
      case (c.reverse ? ~h : h)
         3'h5: d = 6'h11;
         3'h4: d = 6'h21;
         3'h6: d = 6'h22;
         3'h2: d = 6'h0A;
         3'h3: d = 6'h0C;
         3'h1: d = 6'h14;
         default: d = 6'h00;
      endcase
      if (!lo_ok || c.duty_pulse_in_n)
         d[2:0] = 3'h0;
      if (!c.short_brake_n)
         d = 6'h38;
      if (c.run_n || cm)
         d = 6'h00;
      return d;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic drv_chk(input logic lo_ok);
      chk({2'h0, drv}, {2'h0, model(hb, ctl, lo_ok)});
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // A hang counts as a mismatch
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         bad_count++;
         close_out();
      end
   end

   // *****
   // Tests
   // *****
   initial
   begin
      n = $urandom(56687);
      step(16);
      rst <= 1'b0;
      step(1);
      chk({lck, 1'b0, drv}, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 16; i++)
      begin
         hb <= i[2:0];
         ctl <= {3'h2, i[3]};
         cur <= 8'($urandom_range(127));
         step(8);
         drv_chk(1'b1);
         chk({7'h0, oe}, {7'h0, ~^i[2:0]});
         chk({7'h0, od}, 8'h00);
      end
      $display("commutation test done");
      // Enable low must freeze the synchronizers and the drive
      hb <= 3'h4;
      ctl <= 4'h4;
      step(8);
      ce <= 1'b0;
      hb <= 3'h3;
      step(8);
      chk({2'h0, drv}, 8'h21);
      ce <= 1'b1;
      step(8);
      drv_chk(1'b1);
      $display("enable test done");
      // Hall always moves here so the lock timer never runs out
      for (int i = 0; i < 24; i++)
      begin
         hb <= hb ^ 3'(1 + $urandom_range(6));
         ctl <= 4'($urandom);
         cur <= 8'($urandom);
         step(16);
         drv_chk(cur < 8'h80);
      end
      for (int i = 0; i < 2; i++)
      begin
         cm <= 1'b1;
         ctl <= {1'b0, i[0], 2'h0};
         step(8);
         drv_chk(1'b1);
      end
      cm <= 1'b0;
      $display("random control test done");
      for (int k = 0; k < 4; k++)
      begin
         hb <= k[0] ? 3'h5 : 3'h6;
         // pulse input held low while the threshold sets duty
         ctl <= 4'h4;
         cur <= 8'h00;
         thr <= (k == 3) ? 8'h0A : 8'(k * 3);
         step(12);
         n = 0;
         repeat (100)
         begin
            @(posedge clk);
            n += int'(drv.lo != 3'h0);
         end
         chk(8'(n), 8'((k == 3) ? 0 : (10 - 3 * k) * 10));
      end
      $display("duty test done");
      hb <= 3'h1;
      thr <= 8'h00;
      step(LOCK_N + 20);
      chk({7'h0, lck}, 8'h01);
      drv_chk(1'b0);
      ctl.duty_pulse_in_n <= 1'b1;
      step(50);
      chk({7'h0, lck}, 8'h01);
      step(60);
      chk({7'h0, lck}, 8'h00);
      ctl.duty_pulse_in_n <= 1'b0;
      step(LOCK_N + 20);
      chk({7'h0, lck}, 8'h01);
      ctl.run_n <= 1'b1;
      step(6);
      chk({7'h0, lck}, 8'h00);
      ctl.run_n <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         hb <= i[0] ? 3'h3 : 3'h2;
         step(100);
      end
      chk({7'h0, lck}, 8'h00);
      $display("lock test done");
      close_out();
   end
endmodule
`default_nettype wire
